// File: core/adc_conversion_sequencer.sv
// conversion sequencing and output coding for a clocked adc
// Overview of operation
// (RULE1) start conversion on the selected trigger edge
// (RULE2) edge select chooses rising or falling
// (RULE3) sampling ends after the sample interval
// (RULE4) code updates one latency after start
// (RULE5) ready drops on update, restores after delay
// (RULE6) overlapping start accepted past restart spacing
// (RULE7) trigger inside restart spacing is ignored
// (RULE8) configurer keeps spacing below conversion latency
// (RULE9) code width from one to thirty-two
// (RULE10) unsigned, twos complement or offset binary
// (RULE11) code driven after enable latency elapses
// (RULE12) ready starts in configured initial state
// (RULE13) overflow flags start from configured state
// (RULE14) code starts at configured initial value
// (RULE15) span from reference pins, offset half span
// (RULE16) overflow flags mark input outside span
// (RULE17) all intervals are clock counts, fixed parameters
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_sequencer #(
   parameter int                       CODE_WIDTH  = adc_seq_pkg::CODE_WIDTH,
   parameter int                       FIFO_DEPTH  = adc_seq_pkg::FIFO_DEPTH,
   parameter int                       SAMPLE_CYC  = adc_seq_pkg::SAMPLE_CYC,
   parameter int                       CONVERT_CYC = adc_seq_pkg::CONVERT_CYC,
   parameter int                       READY_CYC   = adc_seq_pkg::READY_CYC,
   parameter int                       MIN_CYC     = adc_seq_pkg::MIN_CYC,
   parameter int                       ENABLE_CYC  = adc_seq_pkg::ENABLE_CYC,
   parameter adc_seq_pkg::ready_init_t READY_INIT  = adc_seq_pkg::RDY_READY,
   parameter adc_seq_pkg::ovf_init_t   OVF_INIT    = adc_seq_pkg::OVF_NONE,
   parameter logic [31:0]              INIT_VALUE  = adc_seq_pkg::INIT_CODE
) (
   input  wire logic                           sys_clk,
   input  wire logic                           rst,
   input  wire logic                           trig_clk,
   input  wire adc_seq_pkg::edge_t             edge_select,
   input  wire adc_seq_pkg::code_fmt_t         code_format,
   input  wire logic                           enable,
   input  wire logic signed [CODE_WIDTH+1:0]   analog_in,
   input  wire logic        [CODE_WIDTH:0]     ref_span,
   output logic             [CODE_WIDTH-1:0]   code_out,
   output logic                                code_oe,
   output logic                                data_ready,
   output logic                                positive_overflow_flag,
   output logic                                negative_overflow_flag,
   output logic                                sampling,
   output logic                                start_refused
);
   // counter widths derived from the timing counts, data widths from the code width; see RULE17
   localparam int IW     = CODE_WIDTH + 2;
   localparam int TS_W   = $clog2(CONVERT_CYC + 1) + 1;
   localparam int SW     = $clog2(MIN_CYC + 2) + 1;
   localparam int SCW    = $clog2(SAMPLE_CYC + 1) + 1;
   localparam int RW     = $clog2(READY_CYC + 1) + 1;
   localparam int EW     = $clog2(ENABLE_CYC + 1) + 1;
   localparam int WORD_W = TS_W + 2 + CODE_WIDTH;

   // fixed figures used by the coder, the pop test and the assertions
   localparam logic [IW-1:0]   ONE_W    = IW'(1);
   localparam logic [IW-1:0]   HALF_W   = ONE_W << (CODE_WIDTH - 1);
   localparam logic [TS_W-1:0] POP_AGE  = TS_W'(CONVERT_CYC - 1);
   localparam int              SAMP_END = SAMPLE_CYC + 1;
   localparam int              START_GAP = MIN_CYC + 1;
   localparam int              READY_LAST = READY_CYC - 1;

   logic                      trig_prev_q;
   logic [SW-1:0]             since_q;
   adc_seq_pkg::samp_state_t  samp_state_q;
   logic [SCW-1:0]            samp_cnt_q;
   logic [TS_W-1:0]           now_q;
   logic [TS_W-1:0]           start_ts_q;
   logic [WORD_W-1:0]         word_q;
   logic [CODE_WIDTH-1:0]     code_q;
   logic                      pos_q;
   logic                      neg_q;
   logic                      ready_q;
   logic [RW-1:0]             rdy_cnt_q;
   logic                      oe_q;
   logic [EW-1:0]             en_cnt_q;
   logic                      sampling_q;
   logic                      refused_q;
   logic                      upd_q;
   logic                      fifo_in_ready;
   logic [WORD_W-1:0]         head_word;
   logic                      head_valid;

   // trigger edge detection; trig_clk is taken as already synchronous
   wire logic rise_w   = trig_clk && !trig_prev_q;
   wire logic fall_w   = !trig_clk && trig_prev_q;
   wire logic edge_w   = (edge_select == adc_seq_pkg::EDGE_FALL) ? fall_w : rise_w;   // see RULE1, see RULE2
   // since_q lags the elapsed count by one, so this is strictly later than the spacing
   wire logic spaced_w = since_q >= SW'(MIN_CYC);                                    // see RULE6, see RULE7
   wire logic idle_w   = (samp_state_q == adc_seq_pkg::SAMP_IDLE);
   // a full buffer or a sample still in flight also refuses the trigger
   wire logic start_w  = edge_w && spaced_w && idle_w && fifo_in_ready;              // see RULE7
   wire logic push_w   = (samp_state_q == adc_seq_pkg::SAMP_PUSH);

   // input span and offset come from the reference pair
   wire logic signed [IW-1:0] span_w  = $signed({1'b0, ref_span});                   // see RULE15
   wire logic signed [IW-1:0] mid_w   = span_w >>> 1;                                // see RULE15
   wire logic                 pos_w   = analog_in >= span_w;                         // see RULE16
   wire logic                 neg_w   = analog_in[IW-1];                             // see RULE16
   wire logic        [IW-1:0] top_w   = span_w - ONE_W;
   wire logic        [IW-1:0] clamp_w = pos_w ? top_w : (neg_w ? '0 : analog_in);
   wire logic        [IW-1:0] twos_w  = clamp_w - mid_w;
   wire logic        [IW-1:0] offs_w  = twos_w + HALF_W;

   // encoding select; an unknown setting falls back to unsigned
   function automatic logic [CODE_WIDTH-1:0] format_code(
      input adc_seq_pkg::code_fmt_t fmt,
      input logic [IW-1:0]          raw,
      input logic [IW-1:0]          twos,
      input logic [IW-1:0]          offs
   );
      case (fmt)
         adc_seq_pkg::FMT_TWOS:   format_code = twos[CODE_WIDTH-1:0];
         adc_seq_pkg::FMT_OFFSET: format_code = offs[CODE_WIDTH-1:0];
         default:                 format_code = raw[CODE_WIDTH-1:0];
      endcase
   endfunction : format_code

   wire logic [CODE_WIDTH-1:0] fmt_w = format_code(code_format, clamp_w, twos_w, offs_w);   // see RULE9, see RULE10

   // head of the buffer is due once its age reaches one less than the latency
   wire logic [TS_W-1:0] head_ts_w  = head_word[WORD_W-1 -: TS_W];
   wire logic [TS_W-1:0] head_age_w = now_q - head_ts_w;
   wire logic            pop_w      = head_valid && (head_age_w >= POP_AGE);         // see RULE4

   // pending conversions wait here until their latency is up
   sync_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_pending (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_data   (word_q),
      .in_valid  (push_w),
      .in_ready  (fifo_in_ready),
      .out_data  (head_word),
      .out_valid (head_valid),
      .out_ready (pop_w)
   );

   // free running timestamp; wrap is harmless as ages stay short
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         now_q <= '0;
      else
         now_q <= now_q + TS_W'(1);
   end

   // trigger history and restart spacing, saturating past the limit
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         trig_prev_q <= 1'b0;
         since_q     <= SW'(MIN_CYC + 1);
         refused_q   <= 1'b0;
      end
      else
      begin
         trig_prev_q <= trig_clk;
         refused_q   <= edge_w && !start_w;                                          // see RULE7
         if (start_w)
            since_q <= '0;
         else if (since_q <= SW'(MIN_CYC))
            since_q <= since_q + SW'(1);
      end
   end

   // sampler: run for the sample interval, then hand the word over
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         samp_state_q <= adc_seq_pkg::SAMP_IDLE;
         samp_cnt_q   <= '0;
         sampling_q   <= 1'b0;
         start_ts_q   <= '0;
         word_q       <= '0;
      end
      else
      begin
         case (samp_state_q)
            adc_seq_pkg::SAMP_IDLE:
               if (start_w)
               begin
                  samp_state_q <= adc_seq_pkg::SAMP_RUN;                             // see RULE1
                  samp_cnt_q   <= SCW'(SAMPLE_CYC);
                  sampling_q   <= 1'b1;
                  start_ts_q   <= now_q;
               end
            adc_seq_pkg::SAMP_RUN:
               if (samp_cnt_q == SCW'(1))
               begin
                  samp_state_q <= adc_seq_pkg::SAMP_PUSH;                            // see RULE3
                  sampling_q   <= 1'b0;
                  word_q       <= {start_ts_q, pos_w, neg_w, fmt_w};
               end
               else
                  samp_cnt_q <= samp_cnt_q - SCW'(1);
            adc_seq_pkg::SAMP_PUSH:
               if (fifo_in_ready)
                  samp_state_q <= adc_seq_pkg::SAMP_IDLE;
            default:
               samp_state_q <= adc_seq_pkg::SAMP_IDLE;
         endcase
      end
   end

   // output code and flags take their start-up values under reset
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         code_q <= INIT_VALUE[CODE_WIDTH-1:0];                                       // see RULE14
         pos_q  <= (OVF_INIT == adc_seq_pkg::OVF_POS);                               // see RULE13
         neg_q  <= (OVF_INIT == adc_seq_pkg::OVF_NEG);                               // see RULE13
         upd_q  <= 1'b0;
      end
      else
      begin
         upd_q <= pop_w;
         if (pop_w)
         begin
            code_q <= head_word[CODE_WIDTH-1:0];                                     // see RULE4
            pos_q  <= head_word[CODE_WIDTH+1];                                       // see RULE16
            neg_q  <= head_word[CODE_WIDTH];                                         // see RULE16
         end
      end
   end

   // data ready: low on each update, back high after the restore delay
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         ready_q   <= READY_INIT;                                                    // see RULE12
         rdy_cnt_q <= '0;
      end
      else if (pop_w)
      begin
         ready_q   <= 1'b0;                                                          // see RULE5
         rdy_cnt_q <= RW'(READY_CYC);
      end
      else if (rdy_cnt_q != '0)
      begin
         rdy_cnt_q <= rdy_cnt_q - RW'(1);
         if (rdy_cnt_q == RW'(1))
            ready_q <= 1'b1;                                                         // see RULE5
      end
   end

   // output enable follows enable after the enable latency, drops at once
   always_ff @(posedge sys_clk)
   begin
      if (rst || !enable)
      begin
         oe_q     <= 1'b0;
         en_cnt_q <= '0;
      end
      else if (!oe_q)
      begin
         if (en_cnt_q == EW'(ENABLE_CYC - 1))
            oe_q <= 1'b1;                                                            // see RULE11
         else
            en_cnt_q <= en_cnt_q + EW'(1);
      end
   end

   // every output comes straight from a flip-flop
   assign code_out               = code_q;
   assign code_oe                = oe_q;
   assign data_ready             = ready_q;
   assign positive_overflow_flag = pos_q;
   assign negative_overflow_flag = neg_q;
   assign sampling               = sampling_q;
   assign start_refused          = refused_q;

   // checks, all on sys_clk and quiet during reset
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence s_start;
      start_w;
   endsequence

   sequence s_update;
      upd_q && !data_ready;
   endsequence

   edge_start_a: assert property (s_start |=> sampling && since_q == '0)             // see RULE1
      else $error("accepted trigger did not begin sampling");

   edge_pol_a: assert property (                                                     // see RULE2
      (edge_select == adc_seq_pkg::EDGE_RISE && fall_w) ||
      (edge_select == adc_seq_pkg::EDGE_FALL && rise_w) |-> !start_w)
      else $error("conversion started on the unselected edge");

   sample_end_a: assert property (s_start |-> ##SAMP_END (!sampling && push_w))     // see RULE3
      else $error("sampling did not end after the sample interval");

   update_time_a: assert property (s_start |-> ##CONVERT_CYC s_update)              // see RULE4
      else $error("output code did not update one latency after start");

   ready_low_a: assert property (pop_w |=> !data_ready && code_out == $past(head_word[CODE_WIDTH-1:0])) // see RULE5
      else $error("data ready not low with the code update");

   ready_restore_a: assert property ($rose(data_ready) |-> $past(rdy_cnt_q) == RW'(1)) // see RULE5
      else $error("data ready restored before the restore delay");

   overlap_ok_a: assert property (                                                   // see RULE6
      s_start ##START_GAP (edge_w && idle_w && fifo_in_ready) |=> sampling && since_q == '0)
      else $error("spaced trigger was not accepted");

   start_spacing_a: assert property (edge_w && since_q < SW'(MIN_CYC) |=> start_refused && since_q != '0) // see RULE7
      else $error("trigger inside restart spacing began a conversion");

   refuse_window_a: assert property (s_start ##[1:MIN_CYC] edge_w |=> start_refused) // see RULE7
      else $error("trigger inside restart spacing was taken");

   ready_hold_a: assert property ($fell(data_ready) |-> ##READY_LAST !data_ready ##1 data_ready) // see RULE5
      else $error("data ready low time differs from the restore delay");

   flag_excl_a: assert property (upd_q |-> !(positive_overflow_flag && negative_overflow_flag)) // see RULE16
      else $error("both overflow flags raised by one update");

   enable_lat_a: assert property ($rose(code_oe) |-> $past(enable, ENABLE_CYC))     // see RULE11
      else $error("code driven before the enable latency");

   enable_off_a: assert property (!enable |=> !code_oe)                             // see RULE11
      else $error("code still driven after enable fell");

   init_state_a: assert property ($fell(rst) |->                                     // see RULE12
      data_ready == READY_INIT && code_out == INIT_VALUE[CODE_WIDTH-1:0] &&
      positive_overflow_flag == (OVF_INIT == adc_seq_pkg::OVF_POS) &&
      negative_overflow_flag == (OVF_INIT == adc_seq_pkg::OVF_NEG))
      else $error("start-up state differs from the initial settings");

endmodule : adc_conversion_sequencer
`default_nettype wire

// File: core/adc_seq_pkg.sv
// shared constants and types for the adc conversion sequencer
package adc_seq_pkg;

   // system clock and interval figures, in nanoseconds
   localparam int CLK_PERIOD_NS = 100;
   localparam int SAMPLE_NS     = 300;
   localparam int CONVERT_NS    = 2000;
   localparam int READY_NS      = 500;
   localparam int MIN_START_NS  = 1000;
   localparam int ENABLE_NS     = 400;

   // least times round up to whole cycles, never below one
   localparam int SAMPLE_CYC  = ((SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) > 0 ?
                                ((SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) : 1;
   localparam int CONVERT_CYC = ((CONVERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) > 0 ?
                                ((CONVERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) : 1;
   localparam int READY_CYC   = ((READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) > 0 ?
                                ((READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) : 1;
   localparam int MIN_CYC     = ((MIN_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) > 0 ?
                                ((MIN_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) : 1;
   localparam int ENABLE_CYC  = ((ENABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) > 0 ?
                                ((ENABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) : 1;

   // code width and buffer depth defaults
   localparam int CODE_WIDTH   = 12;
   localparam int FIFO_DEPTH   = 32;
   localparam logic [31:0] INIT_CODE = 32'h0000_0000;

   typedef enum logic {EDGE_RISE = 1'b0, EDGE_FALL = 1'b1} edge_t;
   typedef enum logic [1:0] {FMT_UNSIGNED = 2'h0, FMT_TWOS = 2'h1, FMT_OFFSET = 2'h2} code_fmt_t;
   typedef enum logic [1:0] {OVF_NONE = 2'h0, OVF_POS = 2'h1, OVF_NEG = 2'h2} ovf_init_t;
   typedef enum logic {RDY_NOT_READY = 1'b0, RDY_READY = 1'b1} ready_init_t;
   typedef enum logic [1:0] {SAMP_IDLE = 2'h0, SAMP_RUN = 2'h1, SAMP_PUSH = 2'h2} samp_state_t;

endpackage : adc_seq_pkg

// File: core/sync_fifo.sv
// single clock fifo with registered read data
`timescale 1ns/100ps
`default_nettype none
module sync_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      count_q;
   logic [WIDTH-1:0] data_q;
   logic             valid_q;

   // pointer wrap that does not need a power-of-two depth
   function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
      next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction : next_ptr

   // handshakes; output register refills when empty or drained
   wire logic push_w = in_valid && in_ready;
   wire logic load_w = (count_q != '0) && (!valid_q || out_ready);

   assign in_ready  = (count_q != (AW + 1)'(DEPTH));
   assign out_data  = data_q;
   assign out_valid = valid_q;

   // storage has no reset, only the pointers, count and output stage do
   always_ff @(posedge sys_clk)
   begin
      if (push_w)
         mem_q[wr_q] <= in_data;
   end

   // pointers, fill count and output stage
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         wr_q    <= '0;
         rd_q    <= '0;
         count_q <= '0;
         valid_q <= 1'b0;
         data_q  <= '0;
      end
      else
      begin
         if (push_w)
            wr_q <= next_ptr(wr_q);
         if (load_w)
         begin
            rd_q   <= next_ptr(rd_q);
            data_q <= mem_q[rd_q];
         end
         if (push_w && !load_w)
            count_q <= count_q + (AW + 1)'(1);
         else if (load_w && !push_w)
            count_q <= count_q - (AW + 1)'(1);
         valid_q <= load_w || (valid_q && !out_ready);
      end
   end
endmodule : sync_fifo
`default_nettype wire

// File: sim/adc_signal_source.sv
// far-side model: conversion trigger pin and scaled analog source
`timescale 1ns/100ps
`default_nettype none
module adc_signal_source #(
   parameter int W = adc_seq_pkg::CODE_WIDTH
) (
   input  wire logic                sys_clk,
   input  wire logic                rst,
   input  wire logic                step,
   input  wire logic signed [W+1:0] level,
   input  wire logic        [W:0]   span,
   output logic                     trig_clk,
   output logic signed      [W+1:0] analog_in,
   output logic             [W:0]   ref_span
);
   // trigger pin moves only on request, so it stands still between conversions
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         trig_clk <= 1'b0;
      else if (step)
         trig_clk <= ~trig_clk;
   end

   // source settles one cycle after a new level is asked for; span kept above zero by the caller
   always_ff @(posedge sys_clk)
   begin
      analog_in <= level;
      ref_span  <= span;
   end
endmodule : adc_signal_source
`default_nettype wire

// File: sim/adc_conversion_sequencer_tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module adc_conversion_sequencer_tb;
   logic                    sys_clk     = 1'b0;
   logic                    rst         = 1'b1;
   logic                    step        = 1'b0;
   logic                    enable      = 1'b0;
   adc_seq_pkg::edge_t      edge_select = adc_seq_pkg::EDGE_RISE;
   adc_seq_pkg::code_fmt_t  code_format = adc_seq_pkg::FMT_UNSIGNED;
   logic signed [13:0]      level       = 14'h0000;
   logic        [12:0]      span        = 13'h1000;
   wire logic               trig_clk;
   wire logic signed [13:0] analog_in;
   wire logic        [12:0] ref_span;
   logic [11:0]             code_out, code_alt;
   logic                    code_oe, data_ready, pos_flag, neg_flag, sampling, start_refused;
   logic                    rdy_alt, pos_alt, neg_alt, samp_d, rdy_d;
   int                      fails = 0, samples_checked = 0, starts = 0, refusals = 0;

   always #50 sys_clk = ~sys_clk;

   adc_signal_source src (.sys_clk(sys_clk), .rst(rst), .step(step), .level(level), .span(span),
      .trig_clk(trig_clk), .analog_in(analog_in), .ref_span(ref_span));

   // default counts keep spacing below conversion time
   adc_conversion_sequencer dut (.sys_clk(sys_clk), .rst(rst), .trig_clk(trig_clk), .edge_select(edge_select),
      .code_format(code_format), .enable(enable), .analog_in(analog_in), .ref_span(ref_span),
      .code_out(code_out), .code_oe(code_oe), .data_ready(data_ready), .positive_overflow_flag(pos_flag),
      .negative_overflow_flag(neg_flag), .sampling(sampling), .start_refused(start_refused));

   // second copy only for the other start-up states
   adc_conversion_sequencer #(.READY_INIT(adc_seq_pkg::RDY_NOT_READY), .OVF_INIT(adc_seq_pkg::OVF_POS),
      .INIT_VALUE(32'h0000_0abc)) dut_alt (.sys_clk(sys_clk), .rst(rst), .trig_clk(trig_clk),
      .edge_select(edge_select), .code_format(code_format), .enable(enable), .analog_in(analog_in),
      .ref_span(ref_span), .code_out(code_alt), .code_oe(), .data_ready(rdy_alt),
      .positive_overflow_flag(pos_alt), .negative_overflow_flag(neg_alt), .sampling(), .start_refused());

   // counts accepted starts and refusals as they happen
   always @(posedge sys_clk)
   begin
      samp_d <= sampling;
      if (sampling === 1'b1 && samp_d === 1'b0)
         starts++;
      if (start_refused === 1'b1)
         refusals++;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick

   // one trigger pin transition
   task automatic toggle;
      @(posedge sys_clk) step <= 1'b1;
      @(posedge sys_clk) step <= 1'b0;
   endtask : toggle

   task automatic wait_ready(input logic v);
      int k;
      k = 0;
      while (data_ready !== v && k < 40)
      begin
         @(negedge sys_clk);
         k++;
      end
   endtask : wait_ready

   task automatic reset_state_check;
      @(negedge sys_clk);
      `CHK(code_out, 12'h000)
      `CHK(code_alt, 12'habc)
      `CHK(data_ready, 1'b1)
      `CHK(rdy_alt, 1'b0)
      `CHK({pos_flag, neg_flag}, 2'b00)
      `CHK({pos_alt, neg_alt}, 2'b10)
      `CHK(code_oe, 1'b0)
   endtask : reset_state_check

   // one rising-edge conversion with its timing measured from the sample window
   task automatic convert(input logic signed [13:0] v, input logic [12:0] s, input adc_seq_pkg::code_fmt_t f,
                          input logic [11:0] c, input logic [1:0] fl);
      int k, n, d, l;
      @(posedge sys_clk) level <= v;
      span <= s;
      code_format <= f;
      tick(2);
      toggle();
      k = 0;
      while (sampling !== 1'b1 && k < 8)
      begin
         @(negedge sys_clk);
         k++;
      end
      n = 0;
      while (sampling === 1'b1 && n < 40)
      begin
         @(negedge sys_clk);
         n++;
      end
      d = n;
      while (data_ready !== 1'b0 && d < 40)
      begin
         @(negedge sys_clk);
         d++;
      end
      l = 0;
      while (data_ready === 1'b0 && l < 40)
      begin
         @(negedge sys_clk);
         l++;
      end
      `CHK(n, adc_seq_pkg::SAMPLE_CYC)
      `CHK(d, adc_seq_pkg::CONVERT_CYC - 1)
      `CHK(l, adc_seq_pkg::READY_CYC)
      `CHK(code_out, c)
      `CHK({pos_flag, neg_flag}, fl)
      toggle();
      tick(4);
   endtask : convert

   // falling edge selected: the rise must not start anything
   task automatic falling_select;
      int s0;
      s0 = starts;
      @(posedge sys_clk) edge_select <= adc_seq_pkg::EDGE_FALL;
      toggle();
      tick(8);
      `CHK(starts, s0)
      toggle();
      tick(6);
      `CHK(starts, s0 + 1)
      tick(30);
      @(posedge sys_clk) edge_select <= adc_seq_pkg::EDGE_RISE;
   endtask : falling_select

   // a trigger inside the spacing is dropped, a later one overlaps the first conversion
   task automatic restart_spacing;
      int s0, r0;
      s0 = starts;
      r0 = refusals;
      @(posedge sys_clk) level <= 14'sd200;
      code_format <= adc_seq_pkg::FMT_UNSIGNED;
      span <= 13'h1000;
      tick(2);
      toggle();
      toggle();
      tick(2);
      toggle();
      toggle();
      level <= 14'sd300;
      tick(1);
      toggle();
      tick(3);
      `CHK(refusals, r0 + 1)
      `CHK(starts, s0 + 2)
      wait_ready(1'b0);
      `CHK(code_out, 12'h0c8)
      wait_ready(1'b1);
      wait_ready(1'b0);
      `CHK(code_out, 12'h12c)
      toggle();
      tick(10);
   endtask : restart_spacing

   // enable dropped early restarts the count, held long enough drives the code
   task automatic enable_latency;
      @(posedge sys_clk) enable <= 1'b1;
      tick(2);
      enable <= 1'b0;
      tick(adc_seq_pkg::ENABLE_CYC + 2);
      `CHK(code_oe, 1'b0)
      enable <= 1'b1;
      tick(adc_seq_pkg::ENABLE_CYC - 1);
      @(negedge sys_clk);
      `CHK(code_oe, 1'b0)
      tick(1);
      @(negedge sys_clk);
      `CHK(code_oe, 1'b1)
      @(posedge sys_clk) enable <= 1'b0;
      tick(1);
      @(negedge sys_clk);
      `CHK(code_oe, 1'b0)
   endtask : enable_latency

   task automatic summarize;
      if (fails == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize

   // about 400 cycles of work expected; cut off at 3000 cycles, well beyond that
   initial
   begin
      #300000;
      fails++;
      summarize();
   end

   initial
   begin
      tick(11);
      reset_state_check();
      @(posedge sys_clk) rst <= 1'b0;
      tick(3);
      convert(14'sd100, 13'h1000, adc_seq_pkg::FMT_UNSIGNED, 12'h064, 2'b00);
      convert(14'sd1000, 13'h0800, adc_seq_pkg::FMT_UNSIGNED, 12'h3e8, 2'b00);
      convert(14'sd1000, 13'h0800, adc_seq_pkg::FMT_TWOS, 12'hfe8, 2'b00);
      convert(14'sd1000, 13'h0800, adc_seq_pkg::FMT_OFFSET, 12'h7e8, 2'b00);
      convert(14'sd5000, 13'h0800, adc_seq_pkg::FMT_UNSIGNED, 12'h7ff, 2'b10);
      convert(-14'sd5, 13'h0800, adc_seq_pkg::FMT_TWOS, 12'hc00, 2'b01);
      convert(14'sd7, 13'h0800, adc_seq_pkg::code_fmt_t'(2'h3), 12'h007, 2'b00);
      falling_select();
      restart_spacing();
      enable_latency();
      summarize();
   end
endmodule : adc_conversion_sequencer_tb
`default_nettype wire
